// File: src/timer_event_counter.sv
// 16-bit count-up timer/event counter with byte-wide register port
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "timer_defines.svh"
module timer_event_counter #(
    parameter int COUNT_WIDTH = 16,
    parameter int DIVIDE = `CLOCK_DIVIDE
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic count_input_pin,
    input wire logic port_a_direction,
    output logic timer_irq
);
    import timer_pkg::*;

    // The byte map and the 8-bit divider only serve these values
    if (COUNT_WIDTH != 16) begin : g_check_width
        $error("timer_event_counter: COUNT_WIDTH must be 16");
    end
    if (DIVIDE < 2) begin : g_check_divide_low
        $error("timer_event_counter: DIVIDE must be at least 2");
    end
    if (DIVIDE > 256) begin : g_check_divide_high
        $error("timer_event_counter: DIVIDE must not exceed 256");
    end

    typedef struct packed {
        logic pin_meta;
        logic pin_sync;
        logic pin_last;
        logic [7:0] div_count;
        logic [15:0] counter;
        logic [15:0] preload;
        logic [7:0] low_write_buf;
        logic [7:0] low_read_buf;
        logic [7:0] control;
        logic irq_enable;
        logic irq_flag;
        logic pulse_active;
        logic [7:0] rdata;
    } state_t;

    state_t q;
    state_t next_q;

    // Control field views
    timer_mode_t mode;
    logic run_bit;
    logic edge_polarity_select;
    logic mode_select_low;
    logic mode_select_high;

    // Register port decode
    logic write_count_low;
    logic write_count_high;
    logic write_control;
    logic write_irq_control;
    logic read_count_low;
    logic read_count_high;
    logic read_control;
    logic read_irq_control;

    // Divider and pin events
    logic div_tick;
    logic pin_rise;
    logic pin_fall;
    logic event_edge;
    logic pulse_start_edge;
    logic active_level;

    // Counting
    logic timer_step;
    logic event_step;
    logic pulse_step;
    logic count_step;
    logic counter_full;
    logic overflow;
    logic [15:0] counter_plus_one;
    logic [15:0] loaded;
    logic flag_clear_request;

    assign mode_select_low = q.control[`CTRL_MODE_LOW_BIT];
    assign mode_select_high = q.control[`CTRL_MODE_HIGH_BIT];
    assign mode = timer_mode_t'({mode_select_high, mode_select_low});
    assign run_bit = q.control[`CTRL_RUN_BIT];
    assign edge_polarity_select = q.control[`CTRL_EDGE_BIT];

    // Strobes are never both high, so the decodes cannot collide
    assign write_count_low = reg_write && (reg_addr == `ADDR_COUNT_LOW);
    assign write_count_high = reg_write && (reg_addr == `ADDR_COUNT_HIGH);
    assign write_control = reg_write && (reg_addr == `ADDR_CONTROL);
    assign write_irq_control = reg_write && (reg_addr == `ADDR_IRQ_CONTROL);
    assign read_count_low = reg_read && (reg_addr == `ADDR_COUNT_LOW);
    assign read_count_high = reg_read && (reg_addr == `ADDR_COUNT_HIGH);
    assign read_control = reg_read && (reg_addr == `ADDR_CONTROL);
    assign read_irq_control = reg_read && (reg_addr == `ADDR_IRQ_CONTROL);

    // Free-running divider; a tick marks each falling edge of the divided clock
    assign div_tick = (q.div_count == 8'(DIVIDE - 1));

    // Only the second synchroniser stage feeds edge logic
    assign pin_rise = q.pin_sync & ~q.pin_last;
    assign pin_fall = ~q.pin_sync & q.pin_last;
    assign event_edge = edge_polarity_select ? pin_fall : pin_rise;

    // Pulse mode starts only on the edge that leaves the idle level
    assign pulse_start_edge = edge_polarity_select ? pin_rise : pin_fall;
    assign active_level = edge_polarity_select ? q.pin_sync : ~q.pin_sync;

    assign timer_step = run_bit && (mode == MODE_TIMER) && div_tick;

    // Pin direction is software's job; event mode ignores the pin while it is an output, pulse mode does not
    assign event_step = run_bit && (mode == MODE_EVENT) && port_a_direction
        && event_edge;

    // The active pin level gates the divided clock in pulse mode; an edge only starts the measurement
    assign pulse_step = run_bit && (mode == MODE_PULSE) && q.pulse_active && active_level
        && div_tick;

    assign count_step = timer_step || event_step || pulse_step;
    assign counter_full = (q.counter == `COUNT_FULL);
    assign overflow = count_step && counter_full;
    assign counter_plus_one = q.counter + 16'h0001;
    assign loaded = {reg_wdata, q.low_write_buf};
    assign flag_clear_request = write_irq_control && reg_wdata[`IRQC_FLAG_BIT];

    assign timer_irq = q.irq_flag & q.irq_enable;
    assign reg_rdata = q.rdata;

    always_comb begin
        next_q = q;

        // Two-stage synchroniser, then the edge history
        next_q.pin_meta = count_input_pin;
        next_q.pin_sync = q.pin_meta;
        next_q.pin_last = q.pin_sync;

        // Divider runs free, so tick spacing never depends on register traffic
        if (div_tick) begin
            next_q.div_count = 8'h00;
        end else begin
            next_q.div_count = q.div_count + 8'h01;
        end

        // Pin modes keep counting in power down, since this block keeps its clock
        if (run_bit && (mode == MODE_PULSE)) begin
            if (!q.pulse_active) begin
                if (pulse_start_edge) begin
                    next_q.pulse_active = 1'b1;
                end
            end else if (!active_level) begin
                // Single shot: stop and leave the width in the counter
                next_q.control[`CTRL_RUN_BIT] = 1'b0;
                next_q.pulse_active = 1'b0;
            end
        end else begin
            next_q.pulse_active = 1'b0;
        end

        // Increment, or reload from preload on passing full count
        if (count_step) begin
            if (counter_full) begin
                next_q.counter = q.preload;
            end else begin
                next_q.counter = counter_plus_one;
            end
        end

        // A same-cycle overflow wins over a software clear
        if (overflow) begin
            next_q.irq_flag = 1'b1;
        end else if (flag_clear_request) begin
            next_q.irq_flag = 1'b0;
        end

        if (write_count_low) begin
            next_q.low_write_buf = reg_wdata;
        end

        if (write_count_high) begin
            next_q.preload = loaded;
            if (!run_bit) begin
                next_q.counter = loaded;
            end
        end

        // A control write also restarts a pulse measurement
        if (write_control) begin
            next_q.control = reg_wdata;
            next_q.pulse_active = 1'b0;
        end

        if (write_irq_control) begin
            next_q.irq_enable = reg_wdata[`IRQC_ENABLE_BIT];
        end

        // Read data stand for one cycle only and are zero otherwise
        next_q.rdata = 8'h00;
        if (read_count_low) begin
            next_q.rdata = q.low_read_buf;
        end
        if (read_count_high) begin
            next_q.rdata = q.counter[15:8];
            next_q.low_read_buf = q.counter[7:0];
        end
        if (read_control) begin
            next_q.rdata = q.control;
        end
        if (read_irq_control) begin
            next_q.rdata[`IRQC_ENABLE_BIT] = q.irq_enable;
            next_q.rdata[`IRQC_FLAG_BIT] = q.irq_flag;
        end
    end

    // Counter and preload keep reset clear for determinism, though software must load them
    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '0;
            q.control <= `CONTROL_RESET;
        end else begin
            q <= next_q;
        end
    end
endmodule // timer_event_counter

// File: src/timer_defines.svh
// Register offsets, field positions and timing counts for the 16-bit timer/event counter
// Summary of operation
// - One 16-bit up-counter with timer, event counter and pulse width modes.
// - Writing count registers loads preload; reading returns live counter contents.
// - Timer and pulse width modes count on system clock divided by four.
// - Timer mode increments once per falling edge of divided clock while running.
// - Event mode counts rising pin edges, or falling edges when edge select set.
// - Passing FFFFH reloads from preload, keeps counting and raises interrupt request.
// - Preload has no defined value after reset; software loads it first (this design resets it to zero).
// - Preload write while stopped also goes straight into the counter.
// - Preload write while running reaches the counter only at next overflow.
// - Low byte write only fills a holding buffer.
// - High byte write loads high byte and moves held low byte in together.
// - High byte read returns counter high byte and latches counter low byte.
// - Low byte read returns the byte latched by the last high byte read.
// - Control bit 4 is the run bit.
// - Control bit 3 selects active edge or level for pin modes.
// - Mode bits high=1 low=0 select interval timer mode.
// - Mode bits high=0 low=1 select event counting on the pin.
// - Overflow interrupt reaches processor only while interrupt enable is set.
// - Event counting continues while the device is powered down.
// - Both mode bits high select pulse width mode on divided clock.
// - Pulse mode counts active level, then clears run bit and ignores edges.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
`define ADDR_COUNT_LOW 2'h0
`define ADDR_COUNT_HIGH 2'h1
`define ADDR_CONTROL 2'h2
`define ADDR_IRQ_CONTROL 2'h3
`define CTRL_RUN_BIT 4
`define CTRL_EDGE_BIT 3
`define CTRL_MODE_LOW_BIT 6
`define CTRL_MODE_HIGH_BIT 7
`define IRQC_ENABLE_BIT 0
`define IRQC_FLAG_BIT 1
`define CONTROL_RESET 8'h00
`define COUNT_FULL 16'hFFFF
`define CLOCK_DIVIDE 4
`endif

// File: src/timer_pkg.sv
// Types for the 16-bit timer/event counter
package timer_pkg;
    typedef enum logic [1:0] {
        MODE_UNUSED = 2'b00,
        MODE_EVENT = 2'b01,
        MODE_TIMER = 2'b10,
        MODE_PULSE = 2'b11
    } timer_mode_t;
endpackage

// File: sim/timer_checker.sv
// Port-level assertions for the timer/event counter
`timescale 1ns/1ps
module timer_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic count_input_pin,
    input wire logic port_a_direction,
    input wire logic timer_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Stopped load of both bytes, then a high byte read
    sequence load_s;
        reg_write && reg_addr == 2'h2 && !reg_wdata[4] ##1 reg_write && reg_addr == 2'h0
        ##1 reg_write && reg_addr == 2'h1 ##1 reg_read && reg_addr == 2'h1;
    endsequence
    AST_RESET: assert property ($fell(rst) |-> reg_rdata == 8'h00 && !timer_irq)
        else $error("state not cleared by reset");
    AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data outside read answer");
    AST_IRQ_HOLD: assert property (
        timer_irq && !(reg_write && reg_addr == 2'h3) |=> timer_irq)
        else $error("irq dropped without clear");
    AST_IRQ_MASK: assert property (
        reg_write && reg_addr == 2'h3 && !reg_wdata[0] |=> !timer_irq)
        else $error("irq passed while disabled");
    AST_IRQ_READ: assert property (
        reg_read && reg_addr == 2'h3 |=> $past(timer_irq) == (reg_rdata[1] && reg_rdata[0]))
        else $error("irq differs from flag and enable");
    AST_CTRL_BACK: assert property (
        reg_write && reg_addr == 2'h2 ##1 reg_read && reg_addr == 2'h2
        |=> {reg_rdata[7:6], reg_rdata[3]} == {$past(reg_wdata[7:6], 2), $past(reg_wdata[3], 2)})
        else $error("control readback wrong");
    AST_HIGH_LOAD: assert property (load_s |=> reg_rdata == $past(reg_wdata, 2))
        else $error("high byte not loaded");
    AST_LOW_LOAD: assert property (
        load_s ##2 reg_read && reg_addr == 2'h0 |=> reg_rdata == $past(reg_wdata, 5))
        else $error("low byte not loaded");
    cover property (timer_irq);
    cover property (load_s);
    cover property (reg_read && reg_addr == 2'h3 ##1 reg_rdata[1]);
endmodule // timer_checker

// File: sim/pin_source.sv
// Model of the external event source on the count input pin
`timescale 1ns/1ps
module pin_source (
    input wire logic core_clk,
    output logic count_input_pin
);
    initial count_input_pin = 1'h0;
    // Levels held w cycles; w of one or more keeps each edge countable
    task toggle(int n, int w);
        repeat (n) begin
            repeat (w) @(posedge core_clk);
            count_input_pin <= ~count_input_pin;
        end
    endtask
endmodule // pin_source

// File: sim/test_timer_event_counter_16bit.sv
// Self-checking bench for the timer/event counter
`timescale 1ns/1ps
module test_timer_event_counter_16bit;
    logic core_clk = 0, rst = 1, reg_write = 0, reg_read = 0, port_a_direction = 0;
    logic [1:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata;
    logic count_input_pin, timer_irq;
    logic [15:0] v;
    int err_count = 0, total_checks = 0;
    timer_event_counter timer_event_counter_inst (.core_clk, .rst, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .count_input_pin, .port_a_direction, .timer_irq);
    pin_source pin_source_inst (.core_clk, .count_input_pin);
    initial forever #10 core_clk = ~core_clk;
    task chk(string n, logic [15:0] s, logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Strobes stay up until the next call, so back-to-back transfers need no gap
    task bus(logic w, logic r, logic [1:0] a, logic [7:0] d);
        reg_write <= w;
        reg_read <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask
    task rd(logic [1:0] a, output logic [7:0] d);
        bus(0, 1, a, 8'h00);
        reg_read <= 0;
        @(negedge core_clk) d = reg_rdata;
        @(posedge core_clk);
    endtask
    task ld(logic [7:0] c, logic [15:0] p);
        bus(1, 0, 2'h2, c);
        bus(1, 0, 2'h0, p[7:0]);
        bus(1, 0, 2'h1, p[15:8]);
        rd(2'h1, v[15:8]);
        rd(2'h0, v[7:0]);
    endtask
    task t_regs;
        rd(2'h2, v[7:0]);
        chk("control reset", v[7:0], 8'h00);
        bus(1, 0, 2'h2, 8'hC8);
        rd(2'h2, v[7:0]);
        chk("control", v[7:0], 8'hC8);
        ld(8'h00, 16'hAA9B);
        chk("count", v, 16'hAA9B);
        bus(1, 0, 2'h0, 8'h55);
        rd(2'h1, v[15:8]);
        rd(2'h0, v[7:0]);
        chk("low buffer", v, 16'hAA9B);
        $display("regs end");
    endtask
    task t_timer;
        bus(1, 0, 2'h3, 8'h01);
        ld(8'h80, 16'hFF00);
        bus(1, 0, 2'h2, 8'h90);
        bus(1, 0, 2'h0, 8'h00);
        bus(1, 0, 2'h1, 8'hF0);
        bus(0, 0, 2'h0, 8'h00);
        repeat (1200) if (timer_irq !== 1) @(posedge core_clk);
        chk("irq", timer_irq, 1);
        if (timer_irq !== 1) results;
        bus(1, 0, 2'h2, 8'h80);
        rd(2'h1, v[15:8]);
        chk("reload", v[15:8], 8'hF0);
        rd(2'h3, v[7:0]);
        chk("flag", v[1:0], 2'h3);
        bus(1, 0, 2'h3, 8'h00);
        bus(0, 0, 2'h0, 8'h00);
        chk("masked", timer_irq, 0);
        bus(1, 0, 2'h3, 8'h03);
        rd(2'h3, v[7:0]);
        chk("flag cleared", v[1:0], 2'h1);
        $display("timer end");
    endtask
    task t_event;
        logic [7:0] c [3] = '{8'h50, 8'h58, 8'h50};
        int tg [3] = '{5, 4, 4};
        int ex [3] = '{3, 2, 0};
        for (int i = 0; i < 3; i++) begin
            port_a_direction <= (i < 2);
            ld(c[i] & 8'hEF, 16'h0000);
            bus(1, 0, 2'h2, c[i]);
            bus(0, 0, 2'h0, 8'h00);
            pin_source_inst.toggle(tg[i], 5);
            repeat (6) @(posedge core_clk);
            rd(2'h1, v[15:8]);
            rd(2'h0, v[7:0]);
            chk("events", v, ex[i]);
        end
        $display("event end");
    endtask
    task t_pulse;
        ld(8'hC0, 16'h0000);
        bus(1, 0, 2'h2, 8'hD0);
        bus(0, 0, 2'h0, 8'h00);
        pin_source_inst.toggle(2, 40);
        repeat (8) @(posedge core_clk);
        rd(2'h2, v[7:0]);
        chk("run cleared", v[4], 0);
        pin_source_inst.toggle(2, 20);
        rd(2'h1, v[15:8]);
        rd(2'h0, v[7:0]);
        chk("width", v >= 9 && v <= 11, 1);
        $display("pulse end");
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 0;
        t_regs;
        t_timer;
        t_event;
        t_pulse;
        results;
    end
endmodule // test_timer_event_counter_16bit
bind timer_event_counter timer_checker timer_checker_inst (.core_clk, .rst, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .count_input_pin, .port_a_direction,
    .timer_irq);
